// ### hw/rcd_pkg.sv
// Constants for the reference clock output divider.
// Assumes a single 125 MHz system clock and an AXI4-Lite register port.
//
// How it works
// - Bit 7 enables generator; clear holds it off
// - Bit 6 drives clock onto output pin
// - Bit 5 drives pad slew limit control
// - Bits 4:3 pick duty 75/50/25/0 percent
// - Codes 111/110/101 divide by 128/64/32
// - Codes 100/011/010 divide by 16/8/4
package rcd_pkg;
	localparam logic [3:0] RCD_CTRL_OFFSET = 4'h0;
	localparam logic [3:0] RCD_STAT_OFFSET = 4'h4;
	localparam logic [7:0] RCD_CTRL_RESET = 8'h00;
	localparam int RCD_EN_BIT = 7;
	localparam int RCD_OE_BIT = 6;
	localparam int RCD_SLR_BIT = 5;
	localparam int RCD_DC_MSB = 4;
	localparam int RCD_DC_LSB = 3;
	localparam int RCD_DIV_MSB = 2;
	localparam int RCD_DIV_LSB = 0;
	localparam int RCD_CNT_W = 7;
	localparam logic [1:0] RCD_RESP_OKAY = 2'h0;
	localparam logic [1:0] RCD_RESP_SLVERR = 2'h2;
endpackage : rcd_pkg

// ### hw/rcd_top.sv
// Reference clock output divider with AXI4-Lite control register.
// Assumes bus and base clock are the same SYS_CLK; pad logic lives outside.
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module rcd_top import rcd_pkg::*; (
	input wire logic SYS_CLK,
	input wire logic RESET_N,
	input wire logic [3:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [3:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic REFCLK_OUT_PIN_O,
	output logic REFCLK_OUT_PIN_OE,
	output logic REFCLK_SLEW_LIMIT
);
	// Divider counter width covers the largest ratio, 128
	logic [7:0] ctrl_q;
	logic [RCD_CNT_W-1:0] cnt_q;
	logic aw_got_q, w_got_q;
	logic [3:0] awaddr_q;
	logic [7:0] wdata_q;
	logic wstrb0_q;
	logic clk_q;

	// Write path: address and data taken in either order
	wire aw_hs = S_AXI_AWVALID && S_AXI_AWREADY;
	wire w_hs = S_AXI_WVALID && S_AXI_WREADY;
	wire wr_go = aw_got_q && w_got_q && !S_AXI_BVALID;
	wire wr_ctrl = wr_go && (awaddr_q == RCD_CTRL_OFFSET);
	wire wr_hit = wr_go && ((awaddr_q == RCD_CTRL_OFFSET) || (awaddr_q == RCD_STAT_OFFSET));

	wire module_en = ctrl_q[RCD_EN_BIT];
	wire [1:0] duty_sel = ctrl_q[RCD_DC_MSB:RCD_DC_LSB];
	wire [2:0] div_sel = ctrl_q[RCD_DIV_MSB:RCD_DIV_LSB];

	// Period mask: ratio 2^code, except code 000, which toggles each cycle for ratio 2
	wire [RCD_CNT_W-1:0] cnt_mask = RCD_CNT_W'((8'h01 << div_sel) - 8'h01);
	wire [RCD_CNT_W-1:0] cnt_last = cnt_mask;
	wire [RCD_CNT_W-1:0] cnt_wrap = (cnt_q >= cnt_last) ? '0 : cnt_q + 1'b1;

	// Compare in units of quarter period; fine when the period divides by four
	function automatic logic duty_high(input logic [1:0] dc, input logic [2:0] dv,
		input logic [RCD_CNT_W-1:0] c);
		logic [8:0] q4;
		q4 = 9'({c, 2'b00}) >> dv;
		duty_high = (9'(dc) > q4);
	endfunction : duty_high

	// Codes 000 and 001 both give ratio 2 and cannot show quarter steps; duty is passed as a
	// high phase tracked on SYS_CLK, so 75% and 25% round to 50% there.
	wire fine_ok = (div_sel >= 3'h2);
	wire half_hi = (duty_sel != 2'b00) && ((div_sel == 3'h0) ? !clk_q : (cnt_q == '0));
	wire wave_d = !module_en ? 1'b0 :
		(duty_sel == 2'b00) ? 1'b0 :
		fine_ok ? duty_high(duty_sel, div_sel, cnt_wrap) : half_hi;
	wire [7:0] wmerged = wstrb0_q ? wdata_q : ctrl_q;

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ctrl_q <= RCD_CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_q <= wmerged;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			cnt_q <= '0;
			clk_q <= 1'b0;
		end else if (!module_en) begin
			cnt_q <= '0;
			clk_q <= 1'b0;
		end else begin
			cnt_q <= cnt_wrap;
			clk_q <= wave_d;
		end
	end

	// Pin drive follows registered wave; enable and slew taken straight from control
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			REFCLK_OUT_PIN_O <= 1'b0;
			REFCLK_OUT_PIN_OE <= 1'b0;
			REFCLK_SLEW_LIMIT <= 1'b0;
		end else begin
			REFCLK_OUT_PIN_O <= ctrl_q[RCD_OE_BIT] && wave_d;
			REFCLK_OUT_PIN_OE <= ctrl_q[RCD_OE_BIT];
			REFCLK_SLEW_LIMIT <= ctrl_q[RCD_SLR_BIT];
		end
	end

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb0_q <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= RCD_RESP_OKAY;
		end else begin
			if (aw_hs) begin
				aw_got_q <= 1'b1;
				awaddr_q <= S_AXI_AWADDR;
			end
			if (w_hs) begin
				w_got_q <= 1'b1;
				wdata_q <= S_AXI_WDATA[7:0];
				wstrb0_q <= S_AXI_WSTRB[0];
			end
			if (wr_go) begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= wr_hit ? RCD_RESP_OKAY : RCD_RESP_SLVERR;
			end else if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	// Ready is a registered flag: low while a part is held or a response waits
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
		end else begin
			S_AXI_AWREADY <= !aw_got_q && !aw_hs && !wr_go && !S_AXI_BVALID;
			S_AXI_WREADY <= !w_got_q && !w_hs && !wr_go && !S_AXI_BVALID;
		end
	end

	// Read: control at 0x0, live state at 0x4 (wave level, enable)
	wire ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;
	wire rd_ctrl = (S_AXI_ARADDR == RCD_CTRL_OFFSET);
	wire rd_stat = (S_AXI_ARADDR == RCD_STAT_OFFSET);
	wire [31:0] rd_val = rd_ctrl ? {24'h000000, ctrl_q} :
		rd_stat ? {30'h0, module_en, clk_q} : 32'h00000000;

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= '0;
			S_AXI_RRESP <= RCD_RESP_OKAY;
		end else begin
			S_AXI_ARREADY <= !S_AXI_RVALID && !ar_hs;
			if (ar_hs) begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA <= rd_val;
				S_AXI_RRESP <= (rd_ctrl || rd_stat) ? RCD_RESP_OKAY : RCD_RESP_SLVERR;
			end else if (S_AXI_RVALID && S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
			end
		end
	end
endmodule : rcd_top
`default_nettype wire

// ### verif/rcd_chk.sv
// Checker on pin, enable and slew outputs of rcd_top.
// Assumes AW and W are taken together and writes are spaced apart.
`timescale 1ns/1ps
`default_nettype none
module rcd_chk (
	input wire logic SYS_CLK,
	input wire logic RESET_N,
	input wire logic [3:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic REFCLK_OUT_PIN_O,
	input wire logic REFCLK_OUT_PIN_OE,
	input wire logic REFCLK_SLEW_LIMIT
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N);
	wire logic w = S_AXI_AWVALID & S_AXI_AWREADY & (S_AXI_AWADDR == 4'h0);
	wire logic [7:0] d = S_AXI_WDATA[7:0];
	wire logic p = REFCLK_OUT_PIN_O;
	wire logic on = w & (d[7:6] == 2'h3);
	a_off_low: assert property (w && !d[7] |-> ##6 !p [*2]) else $error("pin high while off");
	a_oe_track: assert property (w |-> ##5 REFCLK_OUT_PIN_OE == $past(d[6], 5)) else $error("oe");
	a_slew_track: assert property (w |-> ##5 REFCLK_SLEW_LIMIT == $past(d[5], 5)) else $error("slew");
	a_dc0_low: assert property (w && d[4:3] == 2'h0 |-> ##6 !p [*2]) else $error("pin high at 0");
	a_div_128: assert property (on && d[4:0] == 5'h17 |-> ##[8:140] $rose(p) ##64 $fell(p))
		else $error("high time at 128");
	a_div_16: assert property (on && d[4:0] == 5'h14 |-> ##[8:30] $rose(p) ##8 $fell(p))
		else $error("high time at 16");
	a_fast_tgl: assert property (on && d[4:0] == 5'h10 |-> ##8 (p != $past(p)) [*4])
		else $error("no toggle");
	c_fast: cover property (on && d[2:0] == 3'h0);
	c_off: cover property (w && !d[7]);
	c_slow: cover property ($fell(p) && REFCLK_SLEW_LIMIT);
endmodule : rcd_chk
bind rcd_top rcd_chk u_rcd_chk (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
	.S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
	.S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
	.REFCLK_OUT_PIN_O(REFCLK_OUT_PIN_O), .REFCLK_OUT_PIN_OE(REFCLK_OUT_PIN_OE),
	.REFCLK_SLEW_LIMIT(REFCLK_SLEW_LIMIT));
`default_nettype wire

// ### verif/rcd_pin_rx.sv
// Receiver on the pin: period and high time, reported at each rise.
// Undriven pin reads low, as through a pull-down.
`timescale 1ns/1ps
`default_nettype none
module rcd_pin_rx (
	input wire logic clk,
	input wire logic o,
	input wire logic oe,
	output logic rise_q,
	output logic [15:0] m_q
);
	logic prev_q = 1'b0;
	wire logic lvl = o & oe;
	wire logic up = lvl & !prev_q;
	logic [7:0] per_q = 8'h0, hi_q = 8'h0;
	always @(posedge clk) begin
		prev_q <= lvl;
		rise_q <= up;
		per_q <= up ? 8'h1 : per_q + 8'h1;
		hi_q <= up ? 8'h1 : hi_q + {7'h0, lvl};
		if (up)
			m_q <= {per_q, hi_q};
	end
endmodule : rcd_pin_rx
`default_nettype wire

// ### verif/tb_top.sv
// Bench: control register over AXI4-Lite, pin wave through rcd_pin_rx.
// Assumes rcd_chk is bound to rcd_top.
`timescale 1ns/1ps
`default_nettype none
module tb_top import rcd_pkg::*; ;
	logic clk = 0, rst_n = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
	logic [3:0] a = 4'h0;
	logic [31:0] wd = 32'h0, r;
	logic [7:0] c, n, st[3] = '{8'hC7, 8'h57, 8'h97};
	logic [15:0] q[$];
	int seed = 32'hACB6D4E5, skip = 0, cyc = 0, err_total = 0, n_compared = 0;
	wire logic awr, wrd, bv, arr, rv, po, poe, slw, rise;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdat;
	wire logic [15:0] m;
	rcd_top u_rcd_top (.SYS_CLK(clk), .RESET_N(rst_n), .S_AXI_AWADDR(a), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wrd), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
		.S_AXI_ARADDR(a), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .REFCLK_OUT_PIN_O(po),
		.REFCLK_OUT_PIN_OE(poe), .REFCLK_SLEW_LIMIT(slw));
	rcd_pin_rx u_rcd_pin_rx (.clk(clk), .o(po), .oe(poe), .rise_q(rise), .m_q(m));
	initial forever #4 clk = ~clk;
	task automatic chk(input string t, input logic [31:0] e, s);
		n_compared++;
		if (e !== s) begin
			err_total++;
			$display("CHECK FAILED %s exp %h got %h", t, e, s);
		end
	endtask : chk
	task automatic wrap_up();
		$display("mismatches %0d of %0d compares", err_total, n_compared);
		if (err_total == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up
	// One bus transfer; readies are sampled mid-cycle so the edge is race free
	task automatic bus(input logic w, input logic [3:0] ad, input logic [31:0] v, e,
		input logic [1:0] er);
		@(posedge clk);
		a <= ad;
		wd <= v;
		{awv, wv, br, arv, rr} <= {w, w, w, !w, !w};
		do @(negedge clk); while (!(w ? awr & wrd : arr));
		@(posedge clk);
		{awv, wv, arv} <= 3'h0;
		do @(negedge clk); while (!(w ? bv : rv));
		chk("resp", er, w ? bresp : rresp);
		if (!w)
			chk("rdata", e, rdat);
		@(posedge clk);
		{br, rr} <= 2'h0;
	endtask : bus
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			wrap_up();
		end
		// First rises after a change may carry the old setting
		if (rise === 1'b1 && q.size() > 0) begin
			if (skip > 0)
				skip--;
			else
				chk("wave", q.pop_front(), m);
		end
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		bus(0, RCD_CTRL_OFFSET, 0, 0, RCD_RESP_OKAY);
		for (int i = 0; i < 16; i++) begin
			r = $random(seed);
			c = {2'h3, r[5], i[3] ? r[4:3] | 2'h1 : 2'h2, i[2:0]};
			n = i[2:0] < 2 ? 8'h2 : 8'h1 << i[2:0];
			bus(1, RCD_CTRL_OFFSET, {r[31:8], c}, 0, RCD_RESP_OKAY);
			@(negedge clk);
			chk("slew", r[5], slw);
			bus(0, RCD_CTRL_OFFSET, r, {24'h0, c}, RCD_RESP_OKAY);
			skip = 3;
			q.push_back({n, i[2:0] < 2 ? 8'h1 : (n >> 2) * c[4:3]});
			while (q.size() > 0) @(posedge clk);
		end
		foreach (st[k]) begin
			bus(1, RCD_CTRL_OFFSET, {24'h0, st[k]}, 0, RCD_RESP_OKAY);
			repeat (8) @(negedge clk);
			repeat (150) begin
				@(negedge clk);
				chk("pin", {1'b0, st[k][6]}, {po, poe});
			end
			// Wave level only predictable while held low
			if (st[k][4:3] == 2'h0 || !st[k][7])
				bus(0, RCD_STAT_OFFSET, 0, {30'h0, st[k][7], 1'b0}, RCD_RESP_OKAY);
		end
		bus(1, 4'h8, 32'h40, 0, RCD_RESP_SLVERR);
		bus(0, 4'h8, 0, 0, RCD_RESP_SLVERR);
		bus(0, RCD_CTRL_OFFSET, 0, 32'h97, RCD_RESP_OKAY);
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
